// [rtcm_pkg.sv]
// Package: constants and types of the RTC two-wire bus controller
package rtcm_pkg;

  // ----------------------------------------------------------------------
  // Bus addressing
  // ----------------------------------------------------------------------
  localparam logic [6:0] RTCM_SLV_ADDR = 7'h68;
  localparam logic RTCM_DIR_WR = 1'b0;
  localparam logic RTCM_DIR_RD = 1'b1;
  localparam logic [3:0] RTCM_ACK_BIT = 4'h8;

  // ----------------------------------------------------------------------
  // Timing: system clock and bus clock, in ns, and derived counts
  // ----------------------------------------------------------------------
  localparam int RTCM_CLK_NS = 100;
  localparam int RTCM_SCL_NS = 10000;
  // Each bus bit is four quarters; a least time, so round up
  localparam int RTCM_QTR_CYC = (RTCM_SCL_NS / 4 + RTCM_CLK_NS - 1) /
                                RTCM_CLK_NS;

  // ----------------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------------
  localparam int RTCM_DATA_W = 8;
  localparam int RTCM_LEN_W = 6;
  localparam int RTCM_FIFO_DEPTH = 32;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic rd;
    logic ptr_en;
    logic [7:0] ptr;
    logic [RTCM_LEN_W-1:0] len;
  } rtcm_cmd_s;

  typedef enum logic [2:0] {
    S_IDLE, S_START, S_BYTE, S_LOAD, S_STOP
  } rtcm_state_e;

  typedef enum logic [2:0] {
    ST_WADDR, ST_PTR, ST_WDATA, ST_RADDR, ST_RDATA
  } rtcm_stage_e;

endpackage : rtcm_pkg

// [rtcm_fifo.sv]
// Module: write-data FIFO between the user and the bus controller
`timescale 1ns/100ps
module rtcm_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 32
) (
  // Clock and control
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  // Filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW:0] wp_ff;
  logic [AW:0] rp_ff;
  logic [AW:0] cnt_ff;
  logic in_rdy_ff;
  logic out_vld_ff;

  // --------------------------------------------------------------------
  // Handshakes and occupancy
  // --------------------------------------------------------------------
  wire push = ce && in_valid && in_rdy_ff;
  wire pop = ce && out_ready && out_vld_ff;
  wire [AW:0] nxt_cnt = cnt_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  assign in_ready = in_rdy_ff;
  assign out_valid = out_vld_ff;
  assign out_data = mem[rp_ff[AW-1:0]];

  // Storage has no reset; only pointers define validity
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wp_ff[AW-1:0]] <= in_data;
    end
  end

  // Pointers and registered full/empty flags
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wp_ff <= '0;
      rp_ff <= '0;
      cnt_ff <= '0;
      in_rdy_ff <= 1'b1;
      out_vld_ff <= 1'b0;
    end else if (ce) begin
      wp_ff <= wp_ff + {{AW{1'b0}}, push};
      rp_ff <= rp_ff + {{AW{1'b0}}, pop};
      cnt_ff <= nxt_cnt;
      in_rdy_ff <= nxt_cnt != (AW+1)'(DEPTH);
      out_vld_ff <= nxt_cnt != '0;
    end
  end

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  AST_FIFO_BOUND: assert property (@(posedge clk_sys) disable iff (rst)
    cnt_ff <= (AW+1)'(DEPTH) && (out_vld_ff == (cnt_ff != '0)))
    else $error("fifo count out of range or valid flag wrong");

endmodule : rtcm_fifo

// [rtcm_host.sv]
// Module: two-wire bus master that reads and writes the RTC registers
`timescale 1ns/100ps
module rtcm_host
  import rtcm_pkg::*;
#(
  parameter int QTR_CYC = RTCM_QTR_CYC,
  parameter int FIFO_DEPTH = RTCM_FIFO_DEPTH
) (
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  // Command port
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire rtcm_cmd_s cmd,
  // Write data stream
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [RTCM_DATA_W-1:0] wr_data,
  // Read data and status
  output logic rd_valid,
  output logic [RTCM_DATA_W-1:0] rd_data,
  output logic done,
  output logic nack_err,
  // Bus pins, open drain
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe
);

  // --------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------
  rtcm_state_e state_ff;
  rtcm_stage_e stage_ff;
  rtcm_cmd_s cmd_ff;
  logic [11:0] qcnt_ff;
  logic [1:0] qtr_ff;
  logic [3:0] bit_ff;
  logic [7:0] sh_ff;
  logic [RTCM_LEN_W-1:0] left_ff;
  logic tx_ff;
  logic ack_ff;
  logic sda_m_ff;
  logic sda_s_ff;
  logic cmd_ready_ff;
  logic rd_valid_ff;
  logic [RTCM_DATA_W-1:0] rd_data_ff;
  logic done_ff;
  logic nack_ff;
  logic scl_oe_ff;
  logic sda_oe_ff;
  logic scl_o_ff;
  logic sda_o_ff;
  logic fifo_valid;
  logic fifo_wr_ready;
  logic [RTCM_DATA_W-1:0] fifo_data;

  // Address byte: seven-bit address above the direction bit
  function automatic logic [7:0] addr_byte(input logic rd);
    addr_byte = {RTCM_SLV_ADDR, rd ? RTCM_DIR_RD : RTCM_DIR_WR};
  endfunction : addr_byte

  // --------------------------------------------------------------------
  // Decoded conditions
  // --------------------------------------------------------------------
  wire running = (state_ff != S_IDLE) && (state_ff != S_LOAD);
  wire tick = ce && running && (qcnt_ff == 12'(QTR_CYC - 1));
  wire in_byte = state_ff == S_BYTE;
  wire ack_phase = bit_ff == RTCM_ACK_BIT;
  wire last_rd = left_ff == RTCM_LEN_W'(1);
  wire byte_end = tick && in_byte && qtr_ff == 2'd3 && ack_phase;
  wire fifo_pop = ce && state_ff == S_LOAD && fifo_valid;
  wire accept = cmd_valid && cmd_ready_ff;
  // Drive low on a zero data bit, or as ACK on all but the last read
  wire nxt_sda_oe = ack_phase ? (!tx_ff && !last_rd)
                              : (tx_ff && !sh_ff[7]);

  assign cmd_ready = cmd_ready_ff;
  assign rd_valid = rd_valid_ff;
  assign rd_data = rd_data_ff;
  assign done = done_ff;
  assign nack_err = nack_ff;
  assign scl_o = scl_o_ff;
  assign scl_oe = scl_oe_ff;
  assign sda_o = sda_o_ff;
  assign sda_oe = sda_oe_ff;

  // --------------------------------------------------------------------
  // Write data buffer; a full buffer stalls the user stream
  // --------------------------------------------------------------------
  rtcm_fifo #(
    .W(RTCM_DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .in_valid(wr_valid),
    .in_ready(fifo_wr_ready),
    .in_data(wr_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );
  assign wr_ready = fifo_wr_ready;

  // SDA comes from the pin; two flops before any use
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sda_m_ff <= 1'b1;
      sda_s_ff <= 1'b1;
    end else if (ce) begin
      sda_m_ff <= sda_i;
      sda_s_ff <= sda_m_ff;
    end
  end

  // Quarter-bit divider; SCL is made here, the device never holds it
  always_ff @(posedge clk_sys) begin
    if (rst || (ce && !running)) begin
      qcnt_ff <= '0;
      qtr_ff <= '0;
    end else if (tick) begin
      qcnt_ff <= '0;
      qtr_ff <= qtr_ff + 2'd1;
    end else if (ce) begin
      qcnt_ff <= qcnt_ff + 12'd1;
    end
  end

  // Sequencer: changes out of START, BYTE and STOP land on a quarter-3 tick; leaving IDLE and LOAD waits for no tick
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_ff <= S_IDLE;
      stage_ff <= ST_WADDR;
      cmd_ff <= '0;
      bit_ff <= '0;
      sh_ff <= '0;
      left_ff <= '0;
      tx_ff <= 1'b1;
      ack_ff <= 1'b0;
      cmd_ready_ff <= 1'b0;
      rd_valid_ff <= 1'b0;
      rd_data_ff <= '0;
      done_ff <= 1'b0;
      nack_ff <= 1'b0;
      scl_oe_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
      scl_o_ff <= 1'b0;
      sda_o_ff <= 1'b0;
    end else if (ce) begin
      rd_valid_ff <= 1'b0;
      done_ff <= 1'b0;
      nack_ff <= 1'b0;
      case (state_ff)
        S_IDLE: begin
          scl_oe_ff <= 1'b0;
          sda_oe_ff <= 1'b0;
          cmd_ready_ff <= !accept;
          if (accept) begin
            cmd_ff <= cmd;
            // A read of zero bytes is taken as one byte
            left_ff <= (cmd.rd && cmd.len == '0) ? RTCM_LEN_W'(1) : cmd.len;
            // Without a pointer the read starts at the device's counter
            stage_ff <= (cmd.rd && !cmd.ptr_en) ? ST_RADDR
                                                : ST_WADDR;
            state_ff <= S_START;
          end
        end
        S_START: begin
          if (tick) begin
            case (qtr_ff)
              2'd0: sda_oe_ff <= 1'b0;
              2'd1: scl_oe_ff <= 1'b0;
              2'd2: sda_oe_ff <= 1'b1;
              default: begin
                scl_oe_ff <= 1'b1;
                sh_ff <= addr_byte(stage_ff == ST_RADDR);
                tx_ff <= 1'b1;
                bit_ff <= '0;
                state_ff <= S_BYTE;
              end
            endcase
          end
        end
        S_BYTE: begin
          if (tick) begin
            case (qtr_ff)
              2'd0: sda_oe_ff <= nxt_sda_oe;
              2'd1: scl_oe_ff <= 1'b0;
              2'd2: begin
                if (ack_phase) begin
                  ack_ff <= !sda_s_ff;
                end else begin
                  sh_ff <= {sh_ff[6:0], sda_s_ff};
                end
              end
              default: begin
                scl_oe_ff <= 1'b1;
                if (!ack_phase) begin
                  bit_ff <= bit_ff + 4'd1;
                end
              end
            endcase
          end
          // Byte finished: choose the next byte or close the frame
          if (byte_end) begin
            bit_ff <= '0;
            case (stage_ff)
              ST_WADDR: begin
                if (!ack_ff) begin
                  nack_ff <= 1'b1;
                  state_ff <= S_STOP;
                end else begin
                  sh_ff <= cmd_ff.ptr;
                  stage_ff <= ST_PTR;
                end
              end
              ST_PTR: begin
                if (!ack_ff) begin
                  nack_ff <= 1'b1;
                  state_ff <= S_STOP;
                end else if (cmd_ff.rd) begin
                  stage_ff <= ST_RADDR;
                  state_ff <= S_START;
                end else if (left_ff == '0) begin
                  state_ff <= S_STOP;
                end else begin
                  stage_ff <= ST_WDATA;
                  state_ff <= S_LOAD;
                end
              end
              ST_WDATA: begin
                left_ff <= left_ff - RTCM_LEN_W'(1);
                if (!ack_ff) begin
                  nack_ff <= 1'b1;
                  state_ff <= S_STOP;
                end else if (left_ff == RTCM_LEN_W'(1)) begin
                  state_ff <= S_STOP;
                end else begin
                  state_ff <= S_LOAD;
                end
              end
              ST_RADDR: begin
                if (!ack_ff) begin
                  nack_ff <= 1'b1;
                  state_ff <= S_STOP;
                end else begin
                  stage_ff <= ST_RDATA;
                  tx_ff <= 1'b0;
                end
              end
              default: begin
                rd_valid_ff <= 1'b1;
                rd_data_ff <= sh_ff;
                left_ff <= left_ff - RTCM_LEN_W'(1);
                if (last_rd) begin
                  state_ff <= S_STOP;
                end
              end
            endcase
          end
        end
        S_LOAD: begin
          // SCL stays low while waiting for the user's next byte
          if (fifo_valid) begin
            sh_ff <= fifo_data;
            tx_ff <= 1'b1;
            bit_ff <= '0;
            state_ff <= S_BYTE;
          end
        end
        default: begin
          if (tick) begin
            case (qtr_ff)
              2'd0: sda_oe_ff <= 1'b1;
              2'd1: scl_oe_ff <= 1'b0;
              2'd2: sda_oe_ff <= 1'b0;
              default: begin
                done_ff <= 1'b1;
                cmd_ready_ff <= 1'b1;
                state_ff <= S_IDLE;
              end
            endcase
          end
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  AST_SDA_LOW_ONLY: assert property (
    (sda_oe_ff || scl_oe_ff) |-> !sda_o_ff && !scl_o_ff)
    else $error("pin driven high");

  AST_SDA_STABLE_HIGH: assert property (
    (in_byte && !scl_oe_ff && $past(!scl_oe_ff)) |-> $stable(sda_oe_ff))
    else $error("SDA moved while SCL high inside a byte");

  AST_START_ONLY: assert property (
    ($rose(sda_oe_ff) && !scl_oe_ff) |-> state_ff == S_START)
    else $error("SDA fell with SCL high outside START");

  AST_STOP_ONLY: assert property (
    ($fell(sda_oe_ff) && !scl_oe_ff) |-> state_ff == S_STOP)
    else $error("SDA rose with SCL high outside STOP");

  AST_WADDR_BYTE: assert property (
    (in_byte && stage_ff == ST_WADDR && bit_ff == '0 && qtr_ff < 2'd2)
      |-> sh_ff == 8'hD0)
    else $error("write address byte is not D0");

  AST_RADDR_BYTE: assert property (
    (in_byte && stage_ff == ST_RADDR && bit_ff == '0 && qtr_ff < 2'd2)
      |-> sh_ff == 8'hD1)
    else $error("read address byte is not D1");

  AST_READ_RELEASE: assert property (
    (in_byte && !tx_ff && !ack_phase && qtr_ff != 2'd0) |-> !sda_oe_ff)
    else $error("SDA held during a read bit");

  AST_LAST_NACK: assert property (
    (in_byte && stage_ff == ST_RDATA && ack_phase && qtr_ff == 2'd2)
      |-> sda_oe_ff == !last_rd)
    else $error("wrong ACK or NACK on read byte");

  AST_RESTART: assert property (
    (byte_end && stage_ff == ST_PTR && ack_ff && cmd_ff.rd)
      |=> state_ff == S_START && stage_ff == ST_RADDR ##1 scl_oe_ff)
    else $error("no repeated START after pointer of a read");

  AST_ADDR_NACK_STOP: assert property (
    (byte_end && stage_ff == ST_WADDR && !ack_ff)
      |=> nack_ff && state_ff == S_STOP)
    else $error("address NACK did not end the frame");

endmodule : rtcm_host

// [rtcm_dev_model.sv]
// Behavioural model of the RTC register device on the two-wire bus
`timescale 1ns/100ps
module rtcm_dev_model
  import rtcm_pkg::*;
(
  // Bus wires, pull-up resolved
  input wire logic scl,
  input wire logic sda,
  // Fault knob: behave as an absent device
  input wire logic refuse,
  // Open-drain pull, high = SDA low
  output logic sda_pull
);
  logic [7:0] mem [0:255];
  logic [7:0] ptr;
  logic [7:0] sh;
  logic [7:0] last_addr;
  logic act;
  logic rd;
  logic tx;
  logic mnack;
  int cnt;
  int ph;
  int n_start;

  // Known contents so reads can be predicted
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = i[7:0] ^ 8'h5a;
    end
    ptr = 8'h00;
    act = 1'b0;
    tx = 1'b0;
    rd = 1'b0;
    sda_pull = 1'b0; // Only ever pulls low, never drives high
    n_start = 0;
  end

  // Start, also mid-byte, restarts the address phase
  always @(negedge sda) begin
    if (scl === 1'b1) begin
      act = 1'b1;
      tx = 1'b0;
      cnt = 0;
      ph = 0;
      sda_pull = 1'b0;
      n_start++;
    end
  end

  // Stop returns the bus to idle
  always @(posedge sda) begin
    if (scl === 1'b1) begin
      act = 1'b0;
      tx = 1'b0;
      sda_pull = 1'b0;
    end
  end

  // Bits are taken on the rising clock edge, MSB first
  always @(posedge scl) begin
    if (act) begin
      if (!tx && cnt < 8) sh = {sh[6:0], sda};
      else if (tx && cnt == 8) mnack = sda;
      cnt++;
    end
  end

  // Outputs change on the falling edge, or are released at start and stop; SCL is never touched
  always @(negedge scl) begin
    if (act) begin
      if (cnt == 8 && !tx) begin
        if (ph == 0) begin
          last_addr = sh;
          rd = sh[0];
          act = (sh[7:1] == RTCM_SLV_ADDR) && !refuse;
        end else if (ph == 1) begin
          ptr = sh;
        end else begin
          mem[ptr] = sh;
          ptr = ptr + 8'h01;
        end
        sda_pull = act; // Ack low, silence is a NACK
      end else if (cnt == 9) begin
        cnt = 0;
        sda_pull = 1'b0;
        tx = rd && (ph == 0 || (tx && !mnack));
        if (tx) begin
          sh = mem[ptr]; // From the current counter
          ptr = ptr + 8'h01;
          sda_pull = ~sh[7];
        end
        if (ph < 2) ph++;
      end else if (tx) begin
        sda_pull = (cnt < 8) ? ~sh[7 - cnt] : 1'b0;
      end
    end
  end
endmodule : rtcm_dev_model

// [tb_rtc_i2c_slave_port.sv]
// Self-checking testbench of the two-wire RTC bus controller
`timescale 1ns/100ps
module tb_rtc_i2c_slave_port
  import rtcm_pkg::*;
;
  logic clk_sys, rst, ce, cmd_valid, cmd_ready, wr_valid, wr_ready;
  logic rd_valid, done, nack_err, scl_o, scl_oe, sda_o, sda_oe;
  logic dev_pull, scl, sda, refuse, saw_nack;
  logic [7:0] wr_data, rd_data;
  logic [7:0] rq[$];
  rtcm_cmd_s cmd;
  int fail_count, n_tests, cyc;

  // --------------------------------------------------------------
  // Clock, wires, design and device
  // --------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // Open drain with pull-ups on both lines
  assign scl = scl_oe ? scl_o : 1'b1;
  assign sda = (sda_oe || dev_pull) ? 1'b0 : 1'b1;

  rtcm_host #(.QTR_CYC(2), .FIFO_DEPTH(32)) DUT (
    .clk_sys(clk_sys), .rst(rst), .ce(ce),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data),
    .rd_valid(rd_valid), .rd_data(rd_data), .done(done),
    .nack_err(nack_err), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda),
    .sda_o(sda_o), .sda_oe(sda_oe));

  rtcm_dev_model DEV (.scl(scl), .sda(sda), .refuse(refuse),
    .sda_pull(dev_pull));

  // Collect read bytes and error pulses; also cut a hang short
  always @(posedge clk_sys) begin
    if (rd_valid === 1'b1) rq.push_back(rd_data);
    if (nack_err === 1'b1) saw_nack = 1'b1;
    cyc++;
    if (cyc == 40000) begin
      fail_count++;
      $display("Error at %0t: run timed out", $time);
      wrap_up();
    end
  end

  // --------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------
  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp,
                            input string what);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : check_byte

  task automatic check_flag(input logic got, input logic exp,
                            input string what);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: %s got %b want %b", $time, what, got, exp);
    end
  endtask : check_flag

  function automatic logic [7:0] pat(input logic [7:0] a);
    return a ^ 8'h5a;
  endfunction : pat

  // Valid held through a burst, so no double drive in one step
  task automatic fill(input logic [7:0] base, input int n);
    int k;
    for (int i = 0; i < n; i++) begin
      wr_valid <= 1'b1;
      wr_data <= base + i[7:0];
      k = 0;
      do begin @(posedge clk_sys); k++; end
      while (wr_ready !== 1'b1 && k < 100);
    end
    wr_valid <= 1'b0;
  endtask : fill

  // One frame: offer, wait for accept, wait for done, bounded
  task automatic run(input logic r, input logic pe, input logic [7:0] p,
                     input logic [5:0] n);
    int k;
    rq.delete();
    saw_nack = 1'b0;
    cmd_valid <= 1'b1;
    cmd <= '{rd: r, ptr_en: pe, ptr: p, len: n};
    k = 0;
    do begin @(posedge clk_sys); k++; end
    while (cmd_ready !== 1'b1 && k < 50);
    cmd_valid <= 1'b0;
    k = 0;
    while (done !== 1'b1 && k < 9000) begin @(posedge clk_sys); k++; end
    check_flag(done, 1'b1, "done");
  endtask : run

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_write;
    fill(8'h11, 3);
    run(1'b0, 1'b0, 8'h10, 6'd3);
    check_byte(DEV.last_addr, 8'hd0, "write address");
    for (int i = 0; i < 3; i++)
      check_byte(DEV.mem[16 + i], 8'h11 + i[7:0], "stored");
    check_byte(DEV.ptr, 8'h13, "counter");
    check_flag(saw_nack, 1'b0, "no nack");
    $display("Test write finished");
  endtask : t_write

  task automatic t_ptr_read;
    int s;
    s = DEV.n_start;
    run(1'b1, 1'b1, 8'h10, 6'd3);
    check_byte(DEV.last_addr, 8'hd1, "read address");
    check_byte(8'(DEV.n_start - s), 8'h02, "starts");
    check_byte(8'(rq.size()), 8'h03, "read count");
    for (int i = 0; i < 3; i++)
      check_byte(rq[i], 8'h11 + i[7:0], "read data");
    check_flag(DEV.act, 1'b0, "bus idle");
    check_flag(sda, 1'b1, "sda released");
    check_flag(scl_o | sda_o, 1'b0, "pins drive low only");
    $display("Test pointer read finished");
  endtask : t_ptr_read

  task automatic t_cur_read;
    run(1'b1, 1'b0, 8'h00, 6'd2);
    check_byte(8'(rq.size()), 8'h02, "read count");
    check_byte(rq[0], pat(8'h13), "current 0");
    check_byte(rq[1], pat(8'h14), "current 1");
    run(1'b0, 1'b0, 8'h40, 6'd0);
    run(1'b1, 1'b0, 8'h00, 6'd0);
    check_byte(rq[0], pat(8'h40), "pointer only");
    $display("Test current read finished");
  endtask : t_cur_read

  task automatic t_refuse;
    refuse <= 1'b1;
    fill(8'h77, 1);
    run(1'b0, 1'b0, 8'h50, 6'd1);
    check_flag(saw_nack, 1'b1, "nack seen");
    check_byte(DEV.mem[80], pat(8'h50), "untouched");
    refuse <= 1'b0;
    run(1'b0, 1'b0, 8'h50, 6'd1);
    check_byte(DEV.mem[80], 8'h77, "kept byte");
    $display("Test refused address finished");
  endtask : t_refuse

  // Data late: the bus must wait with the clock low
  task automatic t_stall;
    fork
      run(1'b0, 1'b0, 8'h60, 6'd2);
      begin
        fill(8'ha0, 1);
        repeat (400) @(posedge clk_sys);
        check_flag(scl, 1'b0, "clock held");
        fill(8'ha1, 1);
      end
    join
    check_byte(DEV.mem[97], 8'ha1, "late byte");
    $display("Test stall finished");
  endtask : t_stall

  task automatic t_full;
    fill(8'hc0, 32);
    wr_valid <= 1'b1;
    wr_data <= 8'hee;
    repeat (2) @(posedge clk_sys);
    check_flag(wr_ready, 1'b0, "fifo full");
    wr_valid <= 1'b0;
    run(1'b0, 1'b0, 8'h80, 6'd32);
    for (int i = 0; i < 32; i++)
      check_byte(DEV.mem[128 + i], 8'hc0 + i[7:0], "burst");
    check_byte(DEV.mem[160], pat(8'ha0), "no extra");
    $display("Test fifo full finished");
  endtask : t_full

  task automatic wrap_up;
    $display("Checks %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up

  // Main sequence
  initial begin
    fail_count = 0;
    n_tests = 0;
    cyc = 0;
    rst = 1'b1;
    ce = 1'b1;
    cmd_valid = 1'b0;
    cmd = '0;
    wr_valid = 1'b0;
    wr_data = 8'h00;
    refuse = 1'b0;
    saw_nack = 1'b0;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    t_write();
    t_ptr_read();
    t_cur_read();
    t_refuse();
    t_stall();
    t_full();
    wrap_up();
  end
endmodule : tb_rtc_i2c_slave_port
